// file: rtl/idwc_top.sv
`timescale 1ns/10ps
module idwc_top #(
    parameter logic [idwc_pkg::CNT_W-1:0] WAIT_PIPED   = idwc_pkg::DEF_WAIT_PIPED,
    parameter logic [idwc_pkg::CNT_W-1:0] WAIT_UNPIPED = idwc_pkg::DEF_WAIT_UNPIPED,
    parameter logic [idwc_pkg::CNT_W-1:0] WAIT_SAME    = idwc_pkg::DEF_WAIT_SAME,
    parameter logic [idwc_pkg::CNT_W-1:0] WAIT_WRITE   = idwc_pkg::DEF_WAIT_WRITE,
    parameter logic                       FAST_POINT   = idwc_pkg::DEF_FAST_POINT,
    parameter logic [idwc_pkg::CNT_W-1:0] PRECHARGE    = idwc_pkg::DEF_PRECHARGE,
    parameter logic [idwc_pkg::CNT_W-1:0] REFRESH_CLKS = idwc_pkg::DEF_REFRESH
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    addr_strobe_n,
    input  wire idwc_pkg::idwc_bus_req_t bus_req,
    input  wire logic                    refresh_req,
    output logic                         ready_n,
    output logic                         next_addr_request_n,
    output logic                         bank0_row_strobe_n,
    output logic                         bank1_row_strobe_n,
    output logic                         refresh_active
);
    import idwc_pkg::*;

    idwc_state_t      state_r;
    idwc_state_t      state_nxt;
    idwc_bus_req_t    req_r;
    idwc_bus_req_t    req_nxt;
    logic             req_pend_r;
    logic             req_pend_nxt;
    logic             piped_r;
    logic             piped_nxt;
    logic             same_r;
    logic             same_nxt;
    logic             refdly_r;
    logic             refdly_nxt;
    logic             refresh_pend_r;
    logic             refresh_pend_nxt;
    logic [CNT_W-1:0] ref_cnt_r;
    logic [CNT_W-1:0] ref_cnt_nxt;
    logic             last_bank_r;
    logic             last_bank_nxt;
    logic             last_valid_r;
    logic             last_valid_nxt;
    logic             ready_n_r;
    logic             ready_n_nxt;
    logic             na_n_r;
    logic             na_n_nxt;
    logic             strobe0_r;
    logic             strobe0_nxt;
    logic             strobe1_r;
    logic             strobe1_nxt;
    logic             refresh_act_r;
    logic             refresh_act_nxt;

    logic             accept;
    logic             pipelined;
    logic             same_back;
    logic             cur_bank;
    logic             bank_ready;
    logic             pre0_ready;
    logic             pre1_ready;
    logic             restart;
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] target;

    // Wait states for one access beyond the two-clock minimum
    function automatic logic [CNT_W-1:0] calc_wait(
        input logic wr,
        input logic same,
        input logic piped
    );
        logic [CNT_W-1:0] w;
        if (same) begin
            w = WAIT_SAME;
        end else if (piped) begin
            w = WAIT_PIPED;
        end else begin
            w = WAIT_UNPIPED;
        end
        if (wr && FAST_POINT) begin
            w = w + WAIT_WRITE;
        end
        return w;
    endfunction

    // True when the access may end in the clock after this one
    function automatic logic ready_due(
        input logic [CNT_W-1:0] el,
        input logic [CNT_W-1:0] tgt,
        input logic             rdly
    );
        logic [CNT_W-1:0] cap;
        cap = FAST_POINT ? REFRESH_CAP_FAST : REFRESH_CAP_SLOW;
        return (el >= tgt) || (rdly && (el >= cap));
    endfunction

    idwc_precharge #(
        .PRE_CLKS   (PRECHARGE)
    ) u_pre0 (
        .clk        (clk),
        .nrst       (nrst),
        .row_active (strobe0_r == STROBE_ON),
        .bank_ready (pre0_ready)
    );

    idwc_precharge #(
        .PRE_CLKS   (PRECHARGE)
    ) u_pre1 (
        .clk        (clk),
        .nrst       (nrst),
        .row_active (strobe1_r == STROBE_ON),
        .bank_ready (pre1_ready)
    );

    idwc_elapsed u_elapsed (
        .clk        (clk),
        .nrst       (nrst),
        .restart    (restart),
        .count      (elapsed)
    );

    // Bus idle or ending: our state machine is idle or refreshing
    assign accept = !addr_strobe_n && bus_req.mem && !bus_req.a31 && !req_pend_r &&
                    ((state_r == ST_IDLE) || (state_r == ST_REFRESH));
    // A request in the clock that ends the last cycle was pipelined
    assign pipelined = !ready_n_r;
    assign same_back = pipelined && last_valid_r && (bus_req.a2 == last_bank_r);
    assign cur_bank = accept ? bus_req.a2 : req_r.a2;
    assign bank_ready = (cur_bank == BANK_ODD) ? pre1_ready : pre0_ready;
    assign restart = accept;
    assign target = accept ? calc_wait(bus_req.write, same_back, pipelined)
                           : calc_wait(req_r.write, same_r, piped_r);

    always_comb begin
        state_nxt        = state_r;
        req_nxt          = req_r;
        req_pend_nxt     = req_pend_r;
        piped_nxt        = piped_r;
        same_nxt         = same_r;
        refdly_nxt       = refdly_r;
        ref_cnt_nxt      = ref_cnt_r;
        last_bank_nxt    = last_bank_r;
        last_valid_nxt   = last_valid_r;
        ready_n_nxt      = 1'h1;
        strobe0_nxt      = STROBE_OFF;
        strobe1_nxt      = STROBE_OFF;
        refresh_pend_nxt = refresh_req | refresh_pend_r;

        if (accept) begin
            req_nxt    = bus_req;
            piped_nxt  = pipelined;
            same_nxt   = same_back;
            refdly_nxt = 1'h0;
        end

        case (state_r)
            ST_IDLE: begin
                if (refresh_pend_r) begin
                    // Refresh wins; a request taken now waits for it
                    state_nxt        = ST_REFRESH;
                    ref_cnt_nxt      = REFRESH_CLKS;
                    refresh_pend_nxt = refresh_req;
                    strobe0_nxt      = STROBE_ON;
                    strobe1_nxt      = STROBE_ON;
                    if (accept) begin
                        req_pend_nxt = 1'h1;
                        refdly_nxt   = 1'h1;
                    end
                end else if (accept && bank_ready) begin
                    // Other bank, or a bank already precharged during idle clocks
                    last_bank_nxt  = bus_req.a2;
                    last_valid_nxt = 1'h1;
                    if (bus_req.a2 == BANK_ODD) begin
                        strobe1_nxt = STROBE_ON;
                    end else begin
                        strobe0_nxt = STROBE_ON;
                    end
                    if (ready_due(CNT_ZERO, target, 1'h0)) begin
                        ready_n_nxt = 1'h0;
                    end else begin
                        state_nxt = ST_ACCESS;
                    end
                end else if (accept) begin
                    state_nxt    = ST_WAIT;
                    req_pend_nxt = 1'h1;
                end
            end

            ST_WAIT: begin
                if (refresh_pend_r) begin
                    state_nxt        = ST_REFRESH;
                    ref_cnt_nxt      = REFRESH_CLKS;
                    refresh_pend_nxt = refresh_req;
                    refdly_nxt       = 1'h1;
                    strobe0_nxt      = STROBE_ON;
                    strobe1_nxt      = STROBE_ON;
                end else if (bank_ready) begin
                    req_pend_nxt   = 1'h0;
                    last_bank_nxt  = req_r.a2;
                    last_valid_nxt = 1'h1;
                    if (req_r.a2 == BANK_ODD) begin
                        strobe1_nxt = STROBE_ON;
                    end else begin
                        strobe0_nxt = STROBE_ON;
                    end
                    // Row opens first, so ready always follows a clock in ACCESS
                    state_nxt = ST_ACCESS;
                end
            end

            ST_ACCESS: begin
                strobe0_nxt = strobe0_r;
                strobe1_nxt = strobe1_r;
                if (ready_due(elapsed, target, refdly_r)) begin
                    ready_n_nxt = 1'h0;
                    state_nxt   = ST_IDLE;
                end
            end

            ST_REFRESH: begin
                // No processor access runs here; requests are only latched
                if (accept) begin
                    req_pend_nxt = 1'h1;
                    refdly_nxt   = 1'h1;
                end
                if (ref_cnt_r <= CNT_ONE) begin
                    ref_cnt_nxt = CNT_ZERO;
                    state_nxt   = (req_pend_r || accept) ? ST_WAIT : ST_IDLE;
                end else begin
                    ref_cnt_nxt = ref_cnt_r - CNT_ONE;
                    strobe0_nxt = STROBE_ON;
                    strobe1_nxt = STROBE_ON;
                end
            end

            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // Pipelined address is invited while an access runs
        na_n_nxt        = (state_nxt != ST_ACCESS);
        refresh_act_nxt = (state_nxt == ST_REFRESH);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r        <= ST_IDLE;
            req_r          <= REQ_RESET;
            req_pend_r     <= 1'h0;
            piped_r        <= 1'h0;
            same_r         <= 1'h0;
            refdly_r       <= 1'h0;
            refresh_pend_r <= 1'h0;
            ref_cnt_r      <= CNT_ZERO;
            last_bank_r    <= BANK_EVEN;
            last_valid_r   <= 1'h0;
            ready_n_r      <= 1'h1;
            na_n_r         <= 1'h1;
            strobe0_r      <= STROBE_OFF;
            strobe1_r      <= STROBE_OFF;
            refresh_act_r  <= 1'h0;
        end else begin
            state_r        <= state_nxt;
            req_r          <= req_nxt;
            req_pend_r     <= req_pend_nxt;
            piped_r        <= piped_nxt;
            same_r         <= same_nxt;
            refdly_r       <= refdly_nxt;
            refresh_pend_r <= refresh_pend_nxt;
            ref_cnt_r      <= ref_cnt_nxt;
            last_bank_r    <= last_bank_nxt;
            last_valid_r   <= last_valid_nxt;
            ready_n_r      <= ready_n_nxt;
            na_n_r         <= na_n_nxt;
            strobe0_r      <= strobe0_nxt;
            strobe1_r      <= strobe1_nxt;
            refresh_act_r  <= refresh_act_nxt;
        end
    end

    assign ready_n             = ready_n_r;
    assign next_addr_request_n = na_n_r;
    assign bank0_row_strobe_n  = strobe0_r;
    assign bank1_row_strobe_n  = strobe1_r;
    assign refresh_active      = refresh_act_r;

endmodule

// file: rtl/idwc_pkg.sv
package idwc_pkg;

    localparam int CNT_W = 4;

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_MAX  = 4'hF;

    // Default wait-state counts, write mode, precharge and refresh clocks, matched to clock rate and DRAM speed
    localparam logic [CNT_W-1:0] DEF_WAIT_PIPED   = 4'h1;
    localparam logic [CNT_W-1:0] DEF_WAIT_UNPIPED = 4'h2;
    localparam logic [CNT_W-1:0] DEF_WAIT_SAME    = 4'h3;
    localparam logic [CNT_W-1:0] DEF_WAIT_WRITE   = 4'h1;
    localparam logic             DEF_FAST_POINT   = 1'h0;
    localparam logic [CNT_W-1:0] DEF_PRECHARGE    = 4'h2;
    localparam logic [CNT_W-1:0] DEF_REFRESH      = 4'h3;

    // Longest wait for an access held off by refresh
    localparam logic [CNT_W-1:0] REFRESH_CAP_FAST = 4'h4;
    localparam logic [CNT_W-1:0] REFRESH_CAP_SLOW = 4'h8;

    localparam logic STROBE_ON  = 1'h0;
    localparam logic STROBE_OFF = 1'h1;
    localparam logic BANK_EVEN  = 1'h0;
    localparam logic BANK_ODD   = 1'h1;

    typedef struct packed {
        logic mem;
        logic write;
        logic a31;
        logic a2;
    } idwc_bus_req_t;

    localparam idwc_bus_req_t REQ_RESET = idwc_bus_req_t'(4'h0);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT    = 2'b01,
        ST_ACCESS  = 2'b10,
        ST_REFRESH = 2'b11
    } idwc_state_t;

endpackage

// file: rtl/idwc_precharge.sv
`timescale 1ns/10ps
module idwc_precharge #(
    parameter logic [idwc_pkg::CNT_W-1:0] PRE_CLKS = idwc_pkg::DEF_PRECHARGE
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic row_active,
    output logic      bank_ready
);
    import idwc_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Held at the full interval while the row is open, then counts down
    always_comb begin
        if (row_active) begin
            cnt_nxt = PRE_CLKS;
        end else if (cnt_r != CNT_ZERO) begin
            cnt_nxt = cnt_r - CNT_ONE;
        end else begin
            cnt_nxt = CNT_ZERO;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Ready one clock early: the row strobe it gates is registered
    assign bank_ready = !row_active && (cnt_r <= CNT_ONE);

endmodule

// file: rtl/idwc_elapsed.sv
`timescale 1ns/10ps
module idwc_elapsed (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       restart,
    output logic [idwc_pkg::CNT_W-1:0]      count
);
    import idwc_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Clocks since the request was taken; saturates
    always_comb begin
        if (restart) begin
            cnt_nxt = CNT_ONE;
        end else if (cnt_r == CNT_MAX) begin
            cnt_nxt = CNT_MAX;
        end else begin
            cnt_nxt = cnt_r + CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count = cnt_r;

endmodule

// file: sim/idwc_assertions.sv
`timescale 1ns/10ps
module idwc_assertions (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    addr_strobe_n,
    input wire idwc_pkg::idwc_bus_req_t bus_req,
    input wire logic                    refresh_req,
    input wire logic                    ready_n,
    input wire logic                    next_addr_request_n,
    input wire logic                    bank0_row_strobe_n,
    input wire logic                    bank1_row_strobe_n,
    input wire logic                    refresh_active
);
    import idwc_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Refresh holds both rows for three clocks with the default count
    sequence s_ref_start;
        $rose(refresh_active);
    endsequence
    sequence s_ref_run;
        refresh_active [*2] ##1 !refresh_active;
    endsequence

    property p_ready_after_row;
        !ready_n |-> $past(next_addr_request_n) == 1'b0;
    endproperty
    property p_ready_with_row;
        !ready_n |-> !(bank0_row_strobe_n && bank1_row_strobe_n);
    endproperty
    property p_one_bank;
        !next_addr_request_n |-> bank0_row_strobe_n != bank1_row_strobe_n;
    endproperty
    property p_refresh_rows;
        refresh_active |-> !bank0_row_strobe_n && !bank1_row_strobe_n;
    endproperty
    // Default precharge is two clocks high
    property p_precharge0;
        $rose(bank0_row_strobe_n) |-> bank0_row_strobe_n [*2];
    endproperty
    property p_precharge1;
        $rose(bank1_row_strobe_n) |-> bank1_row_strobe_n [*2];
    endproperty
    // A good request seen while nothing runs is answered, latched or not
    property p_request_answered;
        !addr_strobe_n && bus_req.mem && !bus_req.a31 && ready_n && next_addr_request_n &&
        bank0_row_strobe_n && bank1_row_strobe_n && !refresh_active |-> ##[1:30] !ready_n;
    endproperty
    property p_refresh_served;
        $rose(refresh_req) |-> ##[1:20] $rose(refresh_active);
    endproperty

    a_ready_one_cycle: assert property (!ready_n |=> ready_n)
        else $error("ready held longer than one cycle");
    a_ready_after_row: assert property (p_ready_after_row)
        else $error("ready without a preceding access phase");
    a_ready_with_row: assert property (p_ready_with_row)
        else $error("ready while no row strobe is active");
    a_one_bank_only: assert property (p_one_bank)
        else $error("access drives other than one row strobe");
    a_refresh_rows: assert property (p_refresh_rows)
        else $error("refresh without both row strobes");
    a_no_ready_refresh: assert property (refresh_active |-> ready_n)
        else $error("cycle ended during refresh");
    a_refresh_length: assert property (s_ref_start |=> s_ref_run)
        else $error("refresh length wrong");
    a_precharge_bank0: assert property (p_precharge0)
        else $error("bank0 precharge too short");
    a_precharge_bank1: assert property (p_precharge1)
        else $error("bank1 precharge too short");
    a_request_answered: assert property (p_request_answered)
        else $error("memory request never answered");
    a_refresh_served: assert property (p_refresh_served)
        else $error("refresh request never served");
endmodule

bind idwc_top idwc_assertions idwc_assertions_i (
    .clk                 (clk),
    .nrst                (nrst),
    .addr_strobe_n       (addr_strobe_n),
    .bus_req             (bus_req),
    .refresh_req         (refresh_req),
    .ready_n             (ready_n),
    .next_addr_request_n (next_addr_request_n),
    .bank0_row_strobe_n  (bank0_row_strobe_n),
    .bank1_row_strobe_n  (bank1_row_strobe_n),
    .refresh_active      (refresh_active)
);

// file: sim/idwc_dram_model.sv
`timescale 1ns/10ps
module idwc_dram_model #(
    parameter int PRE = int'(idwc_pkg::DEF_PRECHARGE)
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic bank0_row_strobe_n,
    input  wire logic bank1_row_strobe_n,
    output logic      viol
);
    logic [1:0] ras_n;
    int         hi [2];

    assign ras_n = {bank1_row_strobe_n, bank0_row_strobe_n};

    // Flags a row restarted before its precharge time ran out
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi[0] = PRE;
            hi[1] = PRE;
            viol  = 1'b0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (!ras_n[b] && hi[b] != 0 && hi[b] < PRE) viol = 1'b1;
                if (ras_n[b]) hi[b]++;
                else hi[b] = 0;
            end
        end
    end
endmodule

// file: sim/tb_idwc_top.sv
`timescale 1ns/10ps
module tb_idwc_top;
    import idwc_pkg::*;

    logic          clk;
    logic          nrst;
    logic          addr_strobe_n;
    idwc_bus_req_t bus_req;
    logic          refresh_req;
    logic          ready_n;
    logic          next_addr_request_n;
    logic          bank0_row_strobe_n;
    logic          bank1_row_strobe_n;
    logic          refresh_active;
    logic          viol;
    int            err_count;
    int            n_checks;
    logic [7:0]    w;
    logic [1:0]    rs;

    localparam logic [7:0] NONE = 8'hFF;

    idwc_top idwc_top_i (
        .clk                 (clk),
        .nrst                (nrst),
        .addr_strobe_n       (addr_strobe_n),
        .bus_req             (bus_req),
        .refresh_req         (refresh_req),
        .ready_n             (ready_n),
        .next_addr_request_n (next_addr_request_n),
        .bank0_row_strobe_n  (bank0_row_strobe_n),
        .bank1_row_strobe_n  (bank1_row_strobe_n),
        .refresh_active      (refresh_active)
    );

    idwc_dram_model idwc_dram_model_i (
        .clk                (clk),
        .nrst               (nrst),
        .bank0_row_strobe_n (bank0_row_strobe_n),
        .bank1_row_strobe_n (bank1_row_strobe_n),
        .viol               (viol)
    );

    always #12.5 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A piped call drives its strobe inside the ready cycle of the previous one
    task automatic access(input logic piped, input logic [3:0] req);
        int n;
        if (!piped) @(posedge clk);
        addr_strobe_n <= 1'b0;
        bus_req       <= idwc_bus_req_t'(req);
        @(posedge clk);
        addr_strobe_n <= 1'b1;
        w = NONE;
        for (n = 1; n < 13 && w == NONE; n++) begin
            @(negedge clk);
            if (ready_n === 1'b0) w = 8'(n - 1);
        end
        rs = {bank1_row_strobe_n, bank0_row_strobe_n};
    endtask

    task automatic t_unpiped();
        access(1'b0, 4'h8);
        check(w, 8'(DEF_WAIT_UNPIPED));
        check(8'(rs), 8'h02);
    endtask

    task automatic t_interleave();
        access(1'b1, 4'h9);
        check(w, 8'(DEF_WAIT_PIPED));
        check(8'(rs), 8'h01);
        access(1'b1, 4'h8);
        check(w, 8'(DEF_WAIT_PIPED));
    endtask

    task automatic t_same_bank();
        access(1'b1, 4'h8);
        check(w, 8'(DEF_WAIT_SAME));
        check({7'h00, viol}, 8'h00);
    endtask

    task automatic t_after_idle();
        repeat (4) @(posedge clk);
        access(1'b0, 4'h8);
        check(w, 8'(DEF_WAIT_UNPIPED));
        access(1'b0, 4'hD);
        check(w, 8'(DEF_WAIT_UNPIPED + (DEF_FAST_POINT ? DEF_WAIT_WRITE : CNT_ZERO)));
    endtask

    task automatic t_refused();
        access(1'b0, 4'hA);
        check(w, NONE);
        access(1'b0, 4'h0);
        check(w, NONE);
    endtask

    task automatic t_refresh();
        int n;
        @(posedge clk);
        refresh_req <= 1'b1;
        @(posedge clk);
        refresh_req <= 1'b0;
        for (n = 0; n < 8 && refresh_active !== 1'b1; n++) @(negedge clk);
        check({7'h00, refresh_active}, 8'h01);
        check({6'h00, bank1_row_strobe_n, bank0_row_strobe_n}, 8'h00);
        access(1'b0, 4'h9);
        check(8'(w <= 8'(REFRESH_CAP_SLOW)), 8'h01);
    endtask

    initial begin
        clk           = 1'b0;
        nrst          = 1'b0;
        addr_strobe_n = 1'b1;
        bus_req       = REQ_RESET;
        refresh_req   = 1'b0;
        err_count     = 0;
        n_checks      = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_unpiped();
        t_interleave();
        t_same_bank();
        t_after_idle();
        t_refused();
        t_refresh();
        repeat (6) @(posedge clk);
        check({7'h00, viol}, 8'h00);
        results();
    end

    // Whole run needs under a hundred clocks
    initial begin
        #75000;
        err_count++;
        results();
    end
endmodule
